//--- rtl/gpwm_pkg.sv
// Package of constants for the gated pulse-train block
package gpwm_pkg;
    localparam int GPWM_CLK_HZ = 100000000;
    localparam int GPWM_STEP_MS = 10;
    localparam int GPWM_STEP_CYC = GPWM_CLK_HZ / 1000 * GPWM_STEP_MS;
    localparam int GPWM_UNIT_MS = 100;
    localparam int GPWM_STEPS_PER_UNIT = GPWM_UNIT_MS / GPWM_STEP_MS;
    localparam logic [15:0] GPWM_PERIOD_MIN = 16'h0001;
    localparam logic [15:0] GPWM_PERIOD_MAX = 16'h7FFF;
    localparam logic [15:0] GPWM_PERIOD_RST = 16'h000A;
    localparam logic [6:0] GPWM_DUTY_MAX = 7'h64;
    localparam logic [6:0] GPWM_DUTY_RST = 7'h00;
    localparam logic [2:0] GPWM_CHAN_RST = 3'h0;
    localparam logic [1:0] GPWM_SRC_RST = 2'h0;
    // Duty source selection codes
    localparam logic [1:0] GPWM_SRC_CONST = 2'h0;
    localparam logic [1:0] GPWM_SRC_ANALOG = 2'h1;
    localparam logic [1:0] GPWM_SRC_BLOCK = 2'h2;
    // Register byte offsets
    localparam logic [3:0] GPWM_REG_CTRL = 4'h0;
    localparam logic [3:0] GPWM_REG_PERIOD = 4'h4;
    localparam logic [3:0] GPWM_REG_CURRENT = 4'h8;
    localparam logic [3:0] GPWM_REG_STATUS = 4'hC;
endpackage

//--- rtl/gpwm_top.sv
// Gated pulse-width modulation generator with a Wishbone register port
// How it works
// - Pulses run only while the synchronised enable input is on.
// - While enabled, periods repeat back to back without a gap.
// - High time is computed from duty percent and period length together.
// - Constant duty accepts 0 to 100 percent, resets to 0.
// - Analogue duty comes from one of eight channels, first by default.
// - Duty may also come from another block's word output.
// - Period is 1 to 32767, each count worth 100 ms.
// - Output is on for the duty length, off for the rest.
// - Set period and whole 100 ms units elapsed in the current period are exported as words.
// - Timing advances in 10 ms steps.
`timescale 1ns/1ns
`default_nettype none
module gpwm_top
    import gpwm_pkg::*;
#(
    parameter int STEP_CYC = GPWM_STEP_CYC
) (
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic enable_i,
    input wire logic [127:0] analog_in_i,
    input wire logic [15:0] block_word_duty_source_i,
    input wire logic [3:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_we_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    output logic pwm_o,
    output logic [15:0] set_period_o,
    output logic [15:0] current_period_o
);
    typedef enum logic [0:0] {GPWM_IDLE, GPWM_RUN} gpwm_state_type;

    // Clamps a raw word to a duty percentage in 0..100
    function automatic logic [6:0] clamp_duty(input logic [15:0] w);
        if (w[15]) begin
            clamp_duty = 7'h00;
        end else if (w > {9'h000, GPWM_DUTY_MAX}) begin
            clamp_duty = GPWM_DUTY_MAX;
        end else begin
            clamp_duty = w[6:0];
        end
    endfunction

    // Enable input comes from a pin: two-flop synchroniser
    logic en_meta;
    logic en_sync;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            en_meta <= 1'b0;
            en_sync <= 1'b0;
        end else begin
            en_meta <= enable_i;
            en_sync <= en_meta;
        end
    end

    // Configuration registers
    logic [6:0] duty_const;
    logic [1:0] duty_src;
    logic [2:0] duty_chan;
    logic [15:0] period_set;

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i;
    wire sel_ctrl = (wb_adr_i == GPWM_REG_CTRL);
    wire sel_period = (wb_adr_i == GPWM_REG_PERIOD);
    wire sel_current = (wb_adr_i == GPWM_REG_CURRENT);
    wire sel_status = (wb_adr_i == GPWM_REG_STATUS);
    wire wr_ctrl = bus_wr && sel_ctrl;
    wire wr_period = bus_wr && sel_period;
    wire [6:0] wr_duty = clamp_duty({8'h00, wb_dat_i[7:0]});
    wire [1:0] wr_src = (wb_dat_i[9:8] == 2'h3) ? GPWM_SRC_CONST
                                                : wb_dat_i[9:8];
    wire [15:0] wr_per_raw = {1'b0, wb_dat_i[14:0]};
    wire [15:0] wr_per = (wr_per_raw < GPWM_PERIOD_MIN) ? GPWM_PERIOD_MIN
                                                        : wr_per_raw;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            duty_const <= GPWM_DUTY_RST;
            duty_src <= GPWM_SRC_RST;
            duty_chan <= GPWM_CHAN_RST;
            period_set <= GPWM_PERIOD_RST;
        end else begin
            if (wr_ctrl && wb_sel_i[0]) begin
                duty_const <= wr_duty;
            end
            if (wr_ctrl && wb_sel_i[1]) begin
                duty_src <= wr_src;
                duty_chan <= wb_dat_i[12:10];
            end
            if (wr_period && wb_sel_i[0] && wb_sel_i[1]) begin
                period_set <= wr_per;
            end
        end
    end

    // Duty source selection
    wire [15:0] analog_word = analog_in_i[duty_chan*16 +: 16];
    wire [6:0] duty_analog = clamp_duty(analog_word);
    wire [6:0] duty_block = clamp_duty(block_word_duty_source_i);
    wire [6:0] duty_now = (duty_src == GPWM_SRC_ANALOG) ? duty_analog
                        : (duty_src == GPWM_SRC_BLOCK) ? duty_block
                        : duty_const;

    duty_clamp_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        duty_now <= GPWM_DUTY_MAX)
        else $error("duty source over 100");

    // Step tick every 10 ms
    gpwm_state_type state;
    logic [31:0] step_cnt;
    wire step_tick = (step_cnt == 32'(STEP_CYC - 1));
    always_ff @(posedge clk_i) begin
        // Counting only in RUN keeps the first step of a train full length
        if (rst_i || !en_sync || state != GPWM_RUN) begin
            step_cnt <= 32'h00000000;
        end else if (step_tick) begin
            step_cnt <= 32'h00000000;
        end else begin
            step_cnt <= step_cnt + 32'h00000001;
        end
    end

    step_bound_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        step_cnt < 32'(STEP_CYC))
        else $error("step counter overran");

    // Period in 10 ms steps and high time in steps
    logic [18:0] pos_step;
    logic [18:0] per_steps;
    logic [18:0] high_steps;
    logic [15:0] elapsed;
    logic [3:0] unit_step;
    wire [25:0] high_prod = 26'(period_set) * 26'(GPWM_STEPS_PER_UNIT)
                          * 26'(duty_now);
    wire [18:0] next_high = 19'(high_prod / 26'(GPWM_DUTY_MAX));
    wire [18:0] next_per = 19'(period_set) * 19'(GPWM_STEPS_PER_UNIT);
    wire period_end = step_tick && (pos_step == per_steps - 19'h00001);
    wire unit_end = step_tick
                 && (unit_step == 4'(GPWM_STEPS_PER_UNIT - 1));

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= GPWM_IDLE;
            pos_step <= 19'h00000;
            per_steps <= 19'h00000;
            high_steps <= 19'h00000;
            elapsed <= 16'h0000;
            unit_step <= 4'h0;
        end else begin
            case (state)
                GPWM_IDLE: begin
                    pos_step <= 19'h00000;
                    elapsed <= 16'h0000;
                    unit_step <= 4'h0;
                    per_steps <= next_per;
                    high_steps <= next_high;
                    if (en_sync) begin
                        state <= GPWM_RUN;
                    end
                end
                GPWM_RUN: begin
                    if (!en_sync) begin
                        state <= GPWM_IDLE;
                    end else if (period_end) begin
                        pos_step <= 19'h00000;
                        elapsed <= 16'h0000;
                        unit_step <= 4'h0;
                        per_steps <= next_per;
                        high_steps <= next_high;
                    end else if (step_tick) begin
                        pos_step <= pos_step + 19'h00001;
                        unit_step <= unit_end ? 4'h0 : unit_step + 4'h1;
                        if (unit_end) begin
                            elapsed <= elapsed + 16'h0001;
                        end
                    end
                end
                default: begin
                    state <= GPWM_IDLE;
                end
            endcase
        end
    end

    step_place_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (19'(elapsed) * 19'(GPWM_STEPS_PER_UNIT) + 19'(unit_step))
        == pos_step)
        else $error("elapsed units out of step");
    pos_range_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_RUN) |-> (pos_step < per_steps))
        else $error("position beyond period");
    run_start_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_IDLE && en_sync) |=> (state == GPWM_RUN))
        else $error("enable did not start the train");

    // Output and exported words
    wire next_pwm = en_sync && (state == GPWM_RUN)
                 && (pos_step < high_steps);
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pwm_o <= 1'b0;
            set_period_o <= GPWM_PERIOD_RST;
            current_period_o <= 16'h0000;
        end else begin
            pwm_o <= next_pwm;
            set_period_o <= period_set;
            current_period_o <= elapsed;
        end
    end

    pwm_high_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_RUN && en_sync && pos_step < high_steps) |=> pwm_o)
        else $error("pwm low inside high time");
    pwm_low_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_RUN && pos_step >= high_steps) |=> !pwm_o)
        else $error("pwm high after high time");
    idle_off_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_IDLE) |=> !pwm_o)
        else $error("pwm on while idle");
    current_export_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (current_period_o == $past(elapsed)))
        else $error("current period not exported");

    // Read mux and ack
    wire [31:0] rd_ctrl = {19'h00000, duty_chan, duty_src, 1'b0, duty_const};
    wire [31:0] rd_status = {28'h0000000, 1'b0, pwm_o, state == GPWM_RUN,
                             en_sync};
    wire [31:0] next_rdata = sel_ctrl ? rd_ctrl
                           : sel_period ? {16'h0000, period_set}
                           : sel_current ? {16'h0000, elapsed}
                           : sel_status ? rd_status
                           : 32'h00000000;
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? next_rdata : 32'h00000000;
        end
    end

    // Checks
    pwm_gated_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !en_sync |=> !pwm_o)
        else $error("pwm on while disabled");
    idle_reset_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_IDLE) |=> (pos_step == 19'h00000))
        else $error("count not restarted");
    period_range_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (period_set >= GPWM_PERIOD_MIN) && (period_set <= GPWM_PERIOD_MAX))
        else $error("period out of range");
    duty_range_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        duty_const <= GPWM_DUTY_MAX)
        else $error("duty over 100");
    high_len_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        high_steps <= per_steps)
        else $error("high beyond period");
    step_only_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_RUN && en_sync && !step_tick) |=> $stable(pos_step))
        else $error("moved off a step");
    period_wrap_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (state == GPWM_RUN && en_sync && period_end)
        |=> (pos_step == 19'h00000))
        else $error("period did not repeat");
    period_export_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        1'b1 |=> (set_period_o == $past(period_set)))
        else $error("set period not exported");
    ack_once_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
    bus_ack_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o)
        else $error("request not acknowledged");
    ack_idle_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !(wb_cyc_i && wb_stb_i) |=> !wb_ack_o)
        else $error("ack without request");
    rdata_idle_a: assert property (
        @(posedge clk_i) disable iff (rst_i)
        !wb_ack_o |-> (wb_dat_o == 32'h00000000))
        else $error("read data outside ack");
endmodule
`default_nettype wire

//--- bench/gpwm_src_model.sv
// Far-side model supplying analogue channel and block word duty values
`timescale 1ns/1ns
`default_nettype none
module gpwm_src_model (
    input wire logic [2:0] chan_i,
    input wire logic [15:0] duty_i,
    input wire logic [15:0] block_i,
    output wire logic [127:0] analog_o,
    output wire logic [15:0] block_o
);
    // Only the chosen channel carries the duty; a wrong pick reads zero
    assign analog_o = 128'(duty_i) << (16 * chan_i);
    assign block_o = block_i;
endmodule
`default_nettype wire

//--- bench/testbench.sv
// Self-checking bench for the gated pulse-train block
`timescale 1ns/1ns
`default_nettype none
module testbench;
    import gpwm_pkg::*;
    localparam int SC = 10;
    logic clk_i, rst_i, enable_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o, pwm_o;
    logic [3:0] wb_adr_i, wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [2:0] chan;
    logic [15:0] src_duty, blk_duty, block_word, set_period_o, cur;
    logic [127:0] analog_in;
    logic [31:0] rq[$];
    int hq[$];
    int mismatches, num_checks, hw, d;
    integer seed;
    gpwm_top #(.STEP_CYC(SC)) uut (.clk_i(clk_i), .rst_i(rst_i),
        .enable_i(enable_i), .analog_in_i(analog_in),
        .block_word_duty_source_i(block_word), .wb_adr_i(wb_adr_i),
        .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
        .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pwm_o(pwm_o), .set_period_o(set_period_o),
        .current_period_o(cur));
    gpwm_src_model model (.chan_i(chan), .duty_i(src_duty),
        .block_i(blk_duty), .analog_o(analog_in), .block_o(block_word));
    task automatic check_word(input string n, input logic [31:0] e, g);
        num_checks++;
        if (g !== e) begin
            mismatches++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic check_width(input int e, g);
        num_checks++;
        if (g != e) begin
            mismatches++;
            $display("Error pulse width expected %0d seen %0d", e, g);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // A read notes its expected data; the monitor compares it at ack
    task automatic bus(input logic [3:0] a, input logic w,
                       input logic [31:0] dv);
        int n;
        n = 0;
        if (!w) rq.push_back(dv);
        @(posedge clk_i);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= w;
        wb_sel_i <= 4'hF;
        wb_dat_i <= w ? dv : 32'($random(seed));
        do begin
            @(posedge clk_i);
            n++;
        end while (wb_ack_o !== 1'b1 && n < 50);
        if (n >= 50) mismatches++;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    // Enables the block for k whole pulses, then gates it off
    task automatic run(input int k, hi);
        int n;
        n = 0;
        repeat (k) hq.push_back(hi);
        @(posedge clk_i);
        enable_i <= 1'b1;
        repeat (k == 0 ? 25 * SC : 0) @(posedge clk_i);
        // At 25 steps with the reset period, two whole units have passed
        if (k == 0) check_word("current period", 32'h2, 32'(cur));
        while (hq.size() > 0 && n < 1000) begin
            @(posedge clk_i);
            n++;
        end
        if (n >= 1000) mismatches++;
        enable_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        check_word("pwm idle", 32'h0, {31'h0, pwm_o});
        bus(GPWM_REG_CURRENT, 1'b0, 32'h0);
    endtask
    always @(posedge clk_i) begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && rq.size() > 0)
            check_word("read data", rq.pop_front(), wb_dat_o);
        if (pwm_o === 1'b1) begin
            hw <= hw + 1;
        end else begin
            if (hw > 0)
                check_width(hq.size() > 0 ? hq.pop_front() : -1, hw);
            hw <= 0;
        end
    end
    initial begin
        clk_i = 1'b0;
        forever #5 clk_i = ~clk_i;
    end
    initial begin
        #200000;
        mismatches++;
        close_out();
    end
    initial begin
        {rst_i, enable_i, wb_we_i, wb_cyc_i, wb_stb_i} = 5'h10;
        {wb_adr_i, wb_sel_i, wb_dat_i, chan, src_duty, blk_duty} = '0;
        {mismatches, num_checks, hw} = '0;
        seed = 32'hFA1A14E1;
        repeat (5) @(posedge clk_i);
        rst_i <= 1'b0;
        bus(GPWM_REG_CTRL, 1'b0, 32'h0);
        bus(4'h2, 1'b0, 32'h0);
        bus(GPWM_REG_STATUS, 1'b0, 32'h0);
        run(0, 0);
        bus(GPWM_REG_PERIOD, 1'b1, 32'h0);
        bus(GPWM_REG_PERIOD, 1'b0, 32'h1);
        bus(GPWM_REG_PERIOD, 1'b1, 32'hFFFF);
        bus(GPWM_REG_PERIOD, 1'b0, 32'h7FFF);
        check_word("set period", 32'h7FFF, 32'(set_period_o));
        bus(GPWM_REG_PERIOD, 1'b1, 32'h2);
        // Duties stay 10..90 so on and off times exceed a scan
        repeat (3) begin
            d = 10 + ($unsigned($random(seed)) % 81);
            bus(GPWM_REG_CTRL, 1'b1, 32'(d));
            run(3, (20 * d / 100) * SC);
        end
        bus(GPWM_REG_CTRL, 1'b1, 32'h378);
        bus(GPWM_REG_CTRL, 1'b0, 32'h64);
        chan <= 3'($random(seed));
        src_duty <= 16'h0028;
        @(posedge clk_i);
        bus(GPWM_REG_CTRL, 1'b1, 32'h100 | (32'(chan) << 10));
        run(3, 8 * SC);
        blk_duty <= 16'h0046;
        bus(GPWM_REG_CTRL, 1'b1, 32'h200);
        run(3, 14 * SC);
        close_out();
    end
endmodule
`default_nettype wire
